// ### src/isa_glue_consts.svh
// constants for the isa i/o glue block
`ifndef ISA_GLUE_CONSTS_SVH
`define ISA_GLUE_CONSTS_SVH
`define OFS_DATA 3'h0
`define OFS_CMD 3'h1
`define OFS_INPUT 3'h2
`define OFS_OUTPUT 3'h3
`define BIT_SUSPEND_FORCE 6
`define BIT_INT_ENABLE 7
`define OUT_RESET 8'h00
`define LED_LSB 0
`define LED_MSB 3
`define CTRL_WIN_HI 2
`define CTRL_WIN_LO 1
`define CTRL_WIN_SEL 2'b00
`define CMD_BIT 0
`endif

// ### src/isa_glue_pkg.sv
// types shared by the isa i/o glue block
package isa_glue_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WRITE = 3'b010,
        ST_READ = 3'b100
    } access_e;
endpackage

// ### src/sync_if.sv
// interface carrying raw pins into the synchroniser and clean levels out
`timescale 1ns/1ps
interface sync_if;
    // select, two strobes, four status pins and four keys
    logic [10:0] raw;
    logic [10:0] clean;
    modport src (output raw, input clean);
    modport dst (input raw, output clean);
endinterface

// ### src/pin_sync.sv
// two-stage synchroniser for the select, strobe, status and key pin inputs
`timescale 1ns/1ps
module pin_sync (
    input wire logic clk,
    sync_if.dst pins
);
    logic [10:0] meta_q;
    logic [10:0] meta_d;
    logic [10:0] clean_q;
    logic [10:0] clean_d;

    // first stage is read only by the second stage
    always_comb begin
        meta_d = pins.raw;
        clean_d = meta_q;
    end

    always_ff @(posedge clk) begin
        meta_q <= meta_d;
        clean_q <= clean_d;
    end

    assign pins.clean = clean_q;
endmodule

// ### src/isa_io_glue_ports.sv
// isa i/o window glue between the bus and the usb peripheral controller
//
// Summary of operation
// - eight locations; offset 0 passes data both ways
// - offset 1 writes command bytes only
// - offset 2 reads eight status bits
// - offset 3 latches eight control bits
// - offsets 4 to 7 left unclaimed
// - input bits 0-3 are keys, 0 pressed
// - input bits 4,6,7 link, suspend, interrupt
// - input bit 5 high when vbus present
// - output bits 0-3 light test leds
// - output bit 6 forces suspend pin low
// - output bit 7 enables bus interrupt
// - software toggles bit 7 for new edge
// - controller clock output routed to connector
// - irq high when int low and enabled
// - chip select on window, a2a1 zero, strobe
`timescale 1ns/1ps
`include "isa_glue_consts.svh"
module isa_io_glue_ports (
    input wire logic clk,
    input wire logic resetn,
    input wire logic window_sel_n,
    input wire logic [2:0] addr,
    input wire logic iow_n,
    input wire logic ior_n,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_n,
    input wire logic [7:0] ctrl_data_in,
    output logic [7:0] ctrl_data_out,
    output logic ctrl_data_oe_n,
    output logic controller_chip_select_n,
    output logic ctrl_a0,
    output logic ctrl_wr_n,
    output logic ctrl_rd_n,
    input wire logic [3:0] test_key_n,
    input wire logic link_pin,
    input wire logic vbus_present,
    input wire logic suspend_pin,
    input wire logic int_n_pin,
    output logic [3:0] test_led,
    output logic suspend_force_low,
    output logic irq,
    input wire logic controller_clk_in,
    output logic controller_clock_output
);
    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    sync_if pins ();
    logic [3:0] keys_s;
    logic link_s;
    logic vbus_s;
    logic susp_s;
    logic intn_s;
    logic sel_s;
    logic iow_s;
    logic ior_s;

    // strobes and pins are all asynchronous to clk
    assign pins.raw = {window_sel_n, iow_n, ior_n, int_n_pin, suspend_pin,
                       vbus_present, link_pin, test_key_n};
    pin_sync u_sync (
        .clk(clk),
        .pins(pins)
    );
    assign {sel_s, iow_s, ior_s, intn_s, susp_s, vbus_s, link_s, keys_s} = pins.clean;

    // sampled address follows strobe timing; isa holds it stable over the cycle
    logic [2:0] addr1_q;
    logic [2:0] addr2_q;
    logic [7:0] din1_q;
    logic [7:0] din2_q;
    logic [7:0] cdin1_q;
    logic [7:0] cdin2_q;
    logic clk1_q;
    logic clk2_q;
    logic [2:0] addr1_d;
    logic [2:0] addr2_d;
    logic [7:0] din1_d;
    logic [7:0] din2_d;
    logic [7:0] cdin1_d;
    logic [7:0] cdin2_d;
    logic clk1_d;
    logic clk2_d;

    // second stage reads only the first; nothing else looks at the first stage
    always_comb begin
        addr1_d = addr;
        addr2_d = addr1_q;
        din1_d = data_in;
        din2_d = din1_q;
        cdin1_d = ctrl_data_in;
        cdin2_d = cdin1_q;
        clk1_d = controller_clk_in;
        clk2_d = clk1_q;
    end

    always_ff @(posedge clk) begin
        addr1_q <= addr1_d;
        addr2_q <= addr2_d;
        din1_q <= din1_d;
        din2_q <= din2_d;
        cdin1_q <= cdin1_d;
        cdin2_q <= cdin2_d;
        clk1_q <= clk1_d;
        clk2_q <= clk2_d;
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs);
        hit = !sel_s && (a == ofs);
    endfunction

    logic wr_act;
    logic rd_act;
    assign wr_act = !iow_s;
    assign rd_act = !ior_s;

    // ------------------------------------------------------------
    // access state
    // ------------------------------------------------------------
    isa_glue_pkg::access_e st_q;
    isa_glue_pkg::access_e st_d;
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            isa_glue_pkg::ST_IDLE: begin
                if (wr_act) begin
                    st_d = isa_glue_pkg::ST_WRITE;
                end else if (rd_act) begin
                    st_d = isa_glue_pkg::ST_READ;
                end
            end
            isa_glue_pkg::ST_WRITE: begin
                if (!wr_act) begin
                    st_d = isa_glue_pkg::ST_IDLE;
                end
            end
            isa_glue_pkg::ST_READ: begin
                if (!rd_act) begin
                    st_d = isa_glue_pkg::ST_IDLE;
                end
            end
            default: st_d = isa_glue_pkg::ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // output port latch and pin outputs
    // ------------------------------------------------------------
    isa_glue_pkg::byte_t out_q;
    isa_glue_pkg::byte_t out_d;
    logic [7:0] dout_d;
    logic doe_n_d;
    logic cs_n_d;
    logic [7:0] cdout_d;
    logic coe_n_d;
    logic irq_d;

    always_comb begin
        out_d = out_q;
        // latch captured at end of the write strobe, data is settled then
        if (st_q == isa_glue_pkg::ST_WRITE && !wr_act && hit(addr2_q, `OFS_OUTPUT)) begin
            out_d = din2_q;
        end
        // controller selected only in the lower pair of offsets
        cs_n_d = !(!sel_s && addr2_q[`CTRL_WIN_HI:`CTRL_WIN_LO] == `CTRL_WIN_SEL
                   && (wr_act || rd_act));
        cdout_d = din2_q;
        coe_n_d = !(wr_act && !cs_n_d);
        dout_d = 8'h00;
        doe_n_d = 1'b1;
        if (rd_act && hit(addr2_q, `OFS_DATA)) begin
            dout_d = cdin2_q;
            doe_n_d = 1'b0;
        end else if (rd_act && hit(addr2_q, `OFS_INPUT)) begin
            dout_d = {intn_s, susp_s, vbus_s, link_s, keys_s};
            doe_n_d = 1'b0;
        end
        irq_d = !intn_s && out_q[`BIT_INT_ENABLE];
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_q <= isa_glue_pkg::ST_IDLE;
            out_q <= `OUT_RESET;
            data_out <= 8'h00;
            data_oe_n <= 1'b1;
            ctrl_data_out <= 8'h00;
            ctrl_data_oe_n <= 1'b1;
            controller_chip_select_n <= 1'b1;
            ctrl_a0 <= 1'b0;
            ctrl_wr_n <= 1'b1;
            ctrl_rd_n <= 1'b1;
            test_led <= 4'h0;
            suspend_force_low <= 1'b0;
            irq <= 1'b0;
            controller_clock_output <= 1'b0;
        end else begin
            st_q <= st_d;
            out_q <= out_d;
            data_out <= dout_d;
            data_oe_n <= doe_n_d;
            ctrl_data_out <= cdout_d;
            ctrl_data_oe_n <= coe_n_d;
            controller_chip_select_n <= cs_n_d;
            ctrl_a0 <= addr2_q[`CMD_BIT];
            ctrl_wr_n <= iow_s;
            ctrl_rd_n <= ior_s;
            test_led <= out_q[`LED_MSB:`LED_LSB];
            suspend_force_low <= out_q[`BIT_SUSPEND_FORCE];
            irq <= irq_d;
            controller_clock_output <= clk2_q;
        end
    end
endmodule

// ### verification/isa_glue_assertions.sv
// assertions on the isa i/o glue ports
`timescale 1ns/1ps
module isa_glue_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire logic window_sel_n,
    input wire logic [2:0] addr,
    input wire logic iow_n,
    input wire logic ior_n,
    input wire logic data_oe_n,
    input wire logic controller_chip_select_n,
    input wire logic int_n_pin,
    input wire logic irq,
    input wire logic controller_clk_in,
    input wire logic controller_clock_output
);
    // five-cycle holds ride out the sync plus register lag
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_irq_gate: assert property (int_n_pin [*5] |-> !irq)
        else $error("irq without request");
    chk_cs_idle: assert property ((iow_n && ior_n) [*5] |-> controller_chip_select_n)
        else $error("select without strobe");
    chk_cs_offset: assert property (
        (addr[2] || addr[1]) [*5] |-> controller_chip_select_n) else $error("select off range");
    chk_cs_write: assert property (
        (!window_sel_n && !iow_n && addr[2:1] == 2'h0) [*5] |-> !controller_chip_select_n)
        else $error("write not selected");
    chk_no_wo_read: assert property (addr[0] [*5] |-> data_oe_n)
        else $error("write-only place drives bus");
    chk_no_reserved: assert property (addr[2] [*5] |-> data_oe_n)
        else $error("reserved place drives bus");
    chk_in_drive: assert property (
        (!window_sel_n && !ior_n && addr == 3'h2) [*5] |-> !data_oe_n) else $error("no drive");
    chk_clk_copy: assert property (controller_clk_in [*5] |-> controller_clock_output)
        else $error("clock copy low");
    chk_clk_low: assert property (!controller_clk_in [*5] |-> !controller_clock_output)
        else $error("clock copy high");
    chk_cs_read: assert property (
        (!window_sel_n && !ior_n && addr[2:1] == 2'h0) [*5] |-> !controller_chip_select_n)
        else $error("read not selected");
endmodule
bind isa_io_glue_ports isa_glue_checker u_isa_glue_checker (.clk, .resetn, .window_sel_n, .addr,
    .iow_n, .ior_n, .data_oe_n, .controller_chip_select_n, .int_n_pin, .irq, .controller_clk_in,
    .controller_clock_output);

// ### verification/isa_host_model.sv
// bus host model making isa i/o cycles
`timescale 1ns/1ps
module isa_host_model (
    input wire logic clk,
    output logic window_sel_n = 1'b1,
    output logic [2:0] addr = 3'h7,
    output logic iow_n = 1'b1,
    output logic ior_n = 1'b1,
    output logic [7:0] data_in = 8'h00,
    input wire logic [7:0] data_out,
    input wire logic data_oe_n
);
    // one cycle: strobe low five cycles, select held four past the strobe
    task automatic cycle(input logic [2:0] a, input logic wr, input logic [7:0] d,
        output logic [7:0] q, output logic oe_n);
        @(negedge clk);
        window_sel_n = 1'b0;
        addr = a;
        data_in = d;
        @(negedge clk);
        iow_n = !wr;
        ior_n = wr;
        repeat (5) @(negedge clk);
        q = data_out;
        oe_n = data_oe_n;
        iow_n = 1'b1;
        ior_n = 1'b1;
        repeat (4) @(negedge clk);
        window_sel_n = 1'b1;
        data_in = ~d; // released bus must not keep the byte
        repeat (2) @(negedge clk);
    endtask
endmodule

// ### verification/testbench.sv
// self-checking bench for the isa i/o glue ports
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0, resetn = 1'b0, link_pin = 1'b0, vbus_present = 1'b0;
    logic suspend_pin = 1'b0, int_n_pin = 1'b1, controller_clk_in = 1'b0, oe;
    logic [7:0] ctrl_data_in = 8'h00, data_in, data_out, ctrl_data_out, q;
    logic [3:0] test_key_n = 4'hf, test_led;
    logic [2:0] addr;
    logic window_sel_n, iow_n, ior_n, data_oe_n, ctrl_data_oe_n, controller_chip_select_n;
    logic ctrl_a0, ctrl_wr_n, ctrl_rd_n, suspend_force_low, irq, controller_clock_output;
    logic [7:0] port_pins;
    logic [7:0] ctrl_pins;
    // packed views so each compare is a full byte
    assign port_pins = {2'b00, irq, suspend_force_low, test_led};
    assign ctrl_pins = {3'h0, ctrl_a0, ctrl_wr_n, ctrl_rd_n, ctrl_data_oe_n,
                        controller_chip_select_n};
    int n_mismatch = 0;
    int checks = 0;
    isa_io_glue_ports u_isa_io_glue_ports (.clk, .resetn, .window_sel_n, .addr, .iow_n, .ior_n,
        .data_in, .data_out, .data_oe_n, .ctrl_data_in, .ctrl_data_out, .ctrl_data_oe_n,
        .controller_chip_select_n, .ctrl_a0, .ctrl_wr_n, .ctrl_rd_n, .test_key_n, .link_pin,
        .vbus_present, .suspend_pin, .int_n_pin, .test_led, .suspend_force_low, .irq,
        .controller_clk_in, .controller_clock_output);
    isa_host_model u_isa_host_model (.clk, .window_sel_n, .addr, .iow_n, .ior_n, .data_in,
        .data_out, .data_oe_n);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (n_mismatch == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // output port, interrupt gate and the re-arm toggle of bit 7
    task automatic t_out();
        int_n_pin = 1'b0;
        u_isa_host_model.cycle(3'h3, 1'b1, 8'hc5, q, oe);
        chk(port_pins, 8'h35);
        u_isa_host_model.cycle(3'h3, 1'b1, 8'h45, q, oe);
        chk(port_pins, 8'h15);
        u_isa_host_model.cycle(3'h3, 1'b1, 8'h8a, q, oe);
        chk(port_pins, 8'h2a);
        int_n_pin = 1'b1;
        repeat (5) @(negedge clk);
        chk(port_pins, 8'h0a);
    endtask
    // input port levels, then reads of places that must stay off the bus
    task automatic t_in();
        test_key_n = 4'ha;
        link_pin = 1'b1;
        vbus_present = 1'b1;
        u_isa_host_model.cycle(3'h2, 1'b0, 8'h00, q, oe);
        chk(q, 8'hba);
        chk({7'h00, oe}, 8'h00);
        for (int a = 1; a < 8; a++) begin
            if (a != 2) begin
                u_isa_host_model.cycle(a[2:0], 1'b0, 8'h00, q, oe);
                chk({7'h00, oe}, 8'h01);
            end
        end
    endtask
    // data read, then data and command bytes towards the controller
    task automatic t_ctrl();
        ctrl_data_in = 8'h3c;
        fork
            u_isa_host_model.cycle(3'h0, 1'b0, 8'h00, q, oe);
            begin
                repeat (6) @(negedge clk);
                chk(ctrl_pins, 8'h0a);
            end
        join
        chk(q, 8'h3c);
        for (int a = 0; a < 2; a++) begin
            fork
                u_isa_host_model.cycle(a[2:0], 1'b1, 8'ha7 ^ a[7:0], q, oe);
                begin
                    repeat (6) @(negedge clk);
                    chk(ctrl_pins, {3'h0, a[0], 4'h4});
                    chk(ctrl_data_out, 8'ha7 ^ a[7:0]);
                end
            join
        end
    endtask
    initial begin
        forever #4 clk = ~clk;
    end
    // slow controller clock, moved off the sampling edge
    initial begin
        forever begin
            repeat (8) @(negedge clk);
            controller_clk_in = ~controller_clk_in;
        end
    end
    // hang guard
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        repeat (3) @(negedge clk);
        chk(port_pins, 8'h00);
        t_out();
        // request pending and enabled, so reset must visibly drop it
        int_n_pin = 1'b0;
        repeat (5) @(negedge clk);
        resetn = 1'b0;
        @(negedge clk);
        chk(port_pins, 8'h00);
        resetn = 1'b1;
        repeat (3) @(negedge clk);
        chk(port_pins, 8'h00);
        int_n_pin = 1'b1;
        t_in();
        t_ctrl();
        report_and_stop();
    end
endmodule
